// ### src/srrs_params.svh
// Constants of the sectored record ring store
`ifndef SRRS_PARAMS_SVH
`define SRRS_PARAMS_SVH
`define SRRS_SECTORS        5
`define SRRS_SECTOR_SIZE    894
`define SRRS_TOTAL          4470
`define SRRS_KEEP_MIN       3576
`define SRRS_REC_WIDTH      32
`define SRRS_INTERVAL_RST   16'h0004
`define SRRS_QUICK_RST      8'h02
`define SRRS_SLOW_RST       8'h02
`define SRRS_TICK_NS        1000
`define SRRS_CLK_NS         40
`define SRRS_TICK_CYC       ((`SRRS_TICK_NS + `SRRS_CLK_NS - 1) / `SRRS_CLK_NS)
`endif

// ### src/srrs_pkg.sv
// Types of the sectored record ring store
package srrs_pkg;
  typedef enum logic [2:0] {
    SRRS_IDLE  = 3'b001,
    SRRS_ERASE = 3'b010,
    SRRS_WRITE = 3'b100
  } srrs_state_type;
endpackage

// ### src/srrs_mem_if.sv
// Port bundle between the store control and its record memory
`timescale 1ns/1ns
interface srrs_mem_if #(parameter int AW = 13, parameter int DW = 32);
  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic          rdEn;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr,
                input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr,
                output rdData);
endinterface

// ### src/srrs_mem.sv
// Record memory with registered read data
`timescale 1ns/1ns
module srrs_mem #(
  parameter int DEPTH = 4470
) (
  input  wire logic clk,
  srrs_mem_if.mem   port
);
  logic [$bits(port.wrData)-1:0] store [DEPTH];

  always_ff @(posedge clk)
  begin
    if (port.wrEn)
      store[port.wrAddr] <= port.wrData;
    if (port.rdEn)
      port.rdData <= store[port.rdAddr];
  end
endmodule

// ### src/srrs_sectored_record_ring_store.sv
// Sectored record ring store: interval timing, sector erase, write and read pointers
// Behaviour
// RL1 - The record memory is a ring of 5 equal sectors of 894 records each.
// RL2 - At 4470 held records the store is full and space is reclaimed before more records.
// RL3 - Reclaiming erases the whole sector holding the oldest records before writing into it.
// RL4 - After wrap the store keeps at least the newest four sectors and never over 4470 records.
// RL5 - Exactly one record is written per record interval, whatever the measurement rate.
// RL6 - With quick trigger active the interval is the configured interval over the quick divisor.
// RL7 - With slow trigger active and quick trigger off the interval is the configured interval times the slow factor.
// RL8 - The reader should drain so that at most 3576 records build up between transmissions.
// RL9 - Writes walk the sectors in order, wrap to the first, and a read pointer marks the oldest.
`timescale 1ns/1ns
`include "srrs_params.svh"
module srrs_sectored_record_ring_store
  import srrs_pkg::*;
#(
  parameter int SECTORS   = `SRRS_SECTORS,
  parameter int SECT_SIZE = `SRRS_SECTOR_SIZE,
  parameter int DW        = `SRRS_REC_WIDTH,
  parameter int TICK_CYC  = `SRRS_TICK_CYC
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [DW-1:0] measData,
  input  wire logic [15:0]   recInterval,
  input  wire logic [7:0]    quickDivisor,
  input  wire logic [7:0]    slowFactor,
  input  wire logic          quickTrig,
  input  wire logic          slowTrig,
  input  wire logic          rdReq,
  output logic               rdValid,
  output logic [DW-1:0]      rdRecord,
  output logic [12:0]        heldCount,
  output logic               storeFull,
  output logic               recStrobe,
  output logic               eraseBusy
);
  localparam int TOTAL = SECTORS * SECT_SIZE;
  localparam int AW    = 13;

  // ************************************
  // Interval timing
  // ************************************
  logic [15:0] tickCnt_r;
  logic [23:0] intCnt_r;
  logic        tick;
  logic [23:0] baseInt;
  logic [23:0] quickInt;
  logic [23:0] effInt;
  logic        recDue;

  assign tick     = (tickCnt_r == 16'(TICK_CYC - 1));
  assign baseInt  = {8'h00, recInterval};
  assign quickInt = baseInt / {16'h0000, ((quickDivisor == 8'h00) ? 8'h01 : quickDivisor)};
  assign effInt   = quickTrig ? quickInt                                   // RL6
                  : slowTrig  ? baseInt * {16'h0000, slowFactor}              // RL7
                  : baseInt;
  assign recDue   = tick && ((intCnt_r + 24'h000001) >= ((effInt == 24'h0) ? 24'h1 : effInt));

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tickCnt_r <= 16'h0000;
      intCnt_r  <= 24'h000000;
    end
    else
    begin
      tickCnt_r <= tick ? 16'h0000 : tickCnt_r + 16'h0001;
      if (tick)
        intCnt_r <= recDue ? 24'h000000 : intCnt_r + 24'h000001;   // RL5
    end
  end

  // ************************************
  // Ring control
  // ************************************
  srrs_state_type state_r;
  logic [AW-1:0]  wrPtr_r;
  logic [AW-1:0]  rdPtr_r;
  logic [AW-1:0]  oldPtr_r;
  logic [AW-1:0]  count_r;
  logic [AW-1:0]  unread_r;
  logic [DW-1:0]  pend_r;
  logic           rdPend_r;
  logic [AW-1:0]  wrPtrInc;
  logic [AW-1:0]  rdPtrInc;
  logic [AW-1:0]  oldSectEnd;
  logic           full;
  logic           doWrite;
  logic           doRead;
  logic           rdInOld;
  logic           inErase;
  logic [AW-1:0]  keptCount;
  logic [AW-1:0]  rdPtr_nxt;
  logic [AW-1:0]  count_nxt;
  logic [AW-1:0]  unread_nxt;

  assign full       = (count_r == AW'(TOTAL));                                   // RL2
  assign wrPtrInc   = (wrPtr_r == AW'(TOTAL - 1)) ? '0 : wrPtr_r + 1'b1;         // RL9
  assign rdPtrInc   = (rdPtr_r == AW'(TOTAL - 1)) ? '0 : rdPtr_r + 1'b1;
  assign oldSectEnd = (oldPtr_r == AW'(TOTAL - SECT_SIZE)) ? '0
                    : oldPtr_r + AW'(SECT_SIZE);                                 // RL1
  assign doWrite    = (state_r == SRRS_WRITE);
  assign doRead     = rdReq && (unread_r != '0) && !doWrite;
  assign rdInOld    = (unread_r > (count_r - AW'(SECT_SIZE)));
  assign inErase    = (state_r == SRRS_ERASE);
  assign keptCount  = count_r - AW'(SECT_SIZE);                                  // RL4
  assign count_nxt  = inErase ? keptCount                                        // RL3
                    : doWrite ? count_r + 1'b1
                    : count_r;
  assign rdPtr_nxt  = (inErase && rdInOld) ? oldSectEnd
                    : doRead ? rdPtrInc : rdPtr_r;
  assign unread_nxt = (inErase && rdInOld) ? keptCount
                    : doWrite ? unread_r + 1'b1
                    : doRead  ? unread_r - 1'b1
                    : unread_r;

  srrs_mem_if #(.AW(AW), .DW(DW)) memBus ();

  assign memBus.wrEn   = doWrite;
  assign memBus.wrAddr = wrPtr_r;
  assign memBus.wrData = pend_r;
  assign memBus.rdEn   = doRead;
  assign memBus.rdAddr = rdPtr_r;

  srrs_mem #(.DEPTH(TOTAL)) recMem (
    .clk  (clk),
    .port (memBus.mem)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      oldPtr_r <= '0;
    end
    else
    begin
      rdPtr_r <= rdPtr_nxt;
      if (doWrite)
        wrPtr_r <= wrPtrInc;                                                     // RL9
      if (inErase)
        oldPtr_r <= oldSectEnd;                                                  // RL3
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_r  <= '0;
      unread_r <= '0;
    end
    else
    begin
      count_r  <= count_nxt;                                                     // RL4
      unread_r <= unread_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pend_r   <= '0;
      rdPend_r <= 1'b0;
    end
    else
    begin
      rdPend_r <= doRead;
      if ((state_r == SRRS_IDLE) && recDue)
        pend_r <= measData;                                                      // RL5
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= SRRS_IDLE;
    else
      case (state_r)
        SRRS_IDLE:
        begin
          if (recDue)
            state_r <= full ? SRRS_ERASE : SRRS_WRITE;                           // RL2
        end
        SRRS_ERASE:
        begin
          // Drop the oldest whole sector                                  
          state_r <= SRRS_WRITE;
        end
        SRRS_WRITE:
        begin
          state_r <= SRRS_IDLE;
        end
        default:
        begin
          state_r <= SRRS_IDLE;
        end
      endcase
  end

  // ************************************
  // Registered outputs
  // ************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdValid   <= 1'b0;
      heldCount <= '0;
      storeFull <= 1'b0;
      recStrobe <= 1'b0;
      eraseBusy <= 1'b0;
    end
    else
    begin
      rdValid   <= rdPend_r;
      heldCount <= count_r;
      storeFull <= full;
      recStrobe <= doWrite;
      eraseBusy <= (state_r == SRRS_ERASE);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdRecord <= '0;
    else if (rdPend_r)
      rdRecord <= memBus.rdData;
  end
endmodule

// ### dv/srrs_reader.sv
// Reader model that drains the record store
`timescale 1ns/1ns
module srrs_reader (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic drainOn,
  input  wire logic slowDrain,
  output logic      rdReq
);
  logic [1:0] pace_r;
  logic       req_r;
  assign rdReq = req_r;
  // Prompt drain, or one request in four
  always_ff @(posedge clk)
  begin
    pace_r <= srst ? 2'h0 : pace_r + 2'h1;
    req_r  <= !srst && drainOn && (!slowDrain || pace_r == 2'h0);
  end
endmodule

// ### dv/srrs_chk.sv
// Assertions on the record store ports
`timescale 1ns/1ns
module srrs_chk #(
  parameter int SECTORS   = 5,
  parameter int SECT_SIZE = 894
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        rdReq,
  input wire logic        rdValid,
  input wire logic [12:0] heldCount,
  input wire logic        storeFull,
  input wire logic        recStrobe,
  input wire logic        eraseBusy
);
  localparam logic [12:0] FULL = 13'(SECTORS * SECT_SIZE);
  localparam logic [12:0] KEEP = 13'((SECTORS - 1) * SECT_SIZE);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ********
  // Checks
  // ********
  a_full_flag: assert property (storeFull == (heldCount == FULL))
    else $error("full flag wrong");
  a_count_cap: assert property (heldCount <= FULL)
    else $error("count too high");
  a_count_step: assert property (!$past(srst) && $changed(heldCount) |->
    heldCount == $past(heldCount) + 13'h1 || heldCount == $past(heldCount) - 13'(SECT_SIZE))
    else $error("count step wrong");
  a_erase_full: assert property ($rose(eraseBusy) |->
    $past(storeFull) || $past(storeFull, 2) || $past(storeFull, 3))
    else $error("erase while not full");
  a_erase_keep: assert property (eraseBusy |-> ##[0:2] heldCount == KEEP)
    else $error("erase left wrong count");
  a_erase_write: assert property (eraseBusy |-> ##[0:2] recStrobe)
    else $error("no write after erase");
  a_erase_clear: assert property (eraseBusy |=> !storeFull)
    else $error("full after erase");
  a_read_cause: assert property (rdValid |-> $past(rdReq, 2))
    else $error("read without request");
endmodule
bind srrs_sectored_record_ring_store srrs_chk #(.SECTORS(SECTORS), .SECT_SIZE(SECT_SIZE)) chk (
  .clk(clk), .srst(srst), .rdReq(rdReq), .rdValid(rdValid), .heldCount(heldCount),
  .storeFull(storeFull), .recStrobe(recStrobe), .eraseBusy(eraseBusy));

// ### dv/srrs_sectored_record_ring_store_tb.sv
// Bench for the record store
`timescale 1ns/1ns
`include "srrs_params.svh"
module srrs_sectored_record_ring_store_tb;
  logic        clk = 1'b0, srst = 1'b1, quickTrig = 1'b0, slowTrig = 1'b0, drainOn = 1'b1;
  logic        slowDrain = 1'b0, rdReq, rdValid, storeFull, recStrobe, eraseBusy;
  logic [15:0] recInterval = 16'h0008;
  logic [7:0]  quickDiv = 8'h02, slowFac = 8'h03;
  logic [31:0] measData = 32'h0, dataRnd = 32'h38, rdRecord, expQ[$];
  logic [12:0] heldCount;
  wire  [2:0]  evts = {eraseBusy, storeFull, recStrobe};
  int          errTotal = 0, checksDone = 0;
  srrs_sectored_record_ring_store #(.TICK_CYC(1)) uut (.clk(clk), .srst(srst),
    .measData(measData), .recInterval(recInterval), .quickDivisor(quickDiv),
    .slowFactor(slowFac), .quickTrig(quickTrig), .slowTrig(slowTrig), .rdReq(rdReq),
    .rdValid(rdValid), .rdRecord(rdRecord), .heldCount(heldCount), .storeFull(storeFull),
    .recStrobe(recStrobe), .eraseBusy(eraseBusy));
  srrs_reader rdr (.clk(clk), .srst(srst), .drainOn(drainOn), .slowDrain(slowDrain),
    .rdReq(rdReq));
  always #20 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want)
    begin
      errTotal++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_hi(input int k, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (evts[k] !== 1'b1 && n < lim);
    if (evts[k] !== 1'b1)
    begin
      errTotal++;
      $display("[ERR] %0t wait ran out", $time);
      closeOut();
    end
  endtask
  task automatic gap_chk(output int n);
    repeat (3) wait_hi(0, 400, n);
  endtask
  // New data after each record, noted while draining
  always @(posedge clk)
    if (recStrobe === 1'b1)
    begin
      if (drainOn)
        expQ.push_back(measData);
      dataRnd = xs(dataRnd);
      measData <= dataRnd;
    end
  always @(negedge clk)
    if (rdValid === 1'b1)
      check(rdRecord, expQ.size() > 0 ? expQ.pop_front() : 32'hx);
  initial
  begin
    logic [31:0] rnd;
    int          n;
    int          r;
    int          q;
    int          s;
    rnd = 32'h38;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(32'(heldCount), 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      rnd = xs(rnd);
      r = 12 + 2 * int'(rnd % 3);
      q = 2 + (i % 2);
      s = 3 - (i % 2);
      @(posedge clk);
      {quickTrig, slowTrig, slowDrain} <= 3'h0;
      recInterval <= 16'(r);
      quickDiv <= 8'(q);
      slowFac <= 8'(s);
      gap_chk(n);
      check(32'(n), 32'(r));
      @(posedge clk);
      {quickTrig, slowTrig} <= 2'h3;
      gap_chk(n);
      check(32'(n), 32'(r / q));
      @(posedge clk);
      {quickTrig, slowTrig, slowDrain} <= 3'h3;
      gap_chk(n);
      check(32'(n), 32'(r * s));
    end
    @(posedge clk);
    {drainOn, quickTrig, slowTrig} <= 3'h0;
    recInterval <= 16'h0001;
    repeat (8) @(posedge clk);
    expQ.delete();
    wait_hi(1, 20000, n);
    check(32'(heldCount), `SRRS_TOTAL);
    wait_hi(2, 20, n);
    @(negedge clk);
    check(32'(heldCount), `SRRS_TOTAL - `SRRS_SECTOR_SIZE);
    check(32'(storeFull), 32'h0);
    check(32'(recStrobe), 32'h1);
    closeOut();
  end
endmodule
